// ---- hdl/xad_decoder.sv ----
// Purpose: Decode and timed execution of the decimal-adjust and add instructions.
// Assumes: Software loads instruction bytes and operands over AHB-Lite, then starts.
// Notes: Zero-wait-state slave; results and flags commit when the clock count expires.
// Functional notes
// RULE1: Plain opcode values are hex bytes; bracketed groups are d, w and s bits.
// RULE2: Clock counts differ by real or protected mode and by hit or miss.
// RULE3: Nine status flags are kept: overflow through carry.
// RULE4: Each flag is updated, kept, cleared, set or left undefined.
// RULE5: Immediates are 8-bit, 16-bit, or full size chosen by operand size.
// RULE6: Displacements are 8-bit signed or full signed 16 or 32 bits.
// RULE7: Variable counts follow repeat count, frame level, or jump taken.
// RULE8: Privilege-dependent counts compare current against I/O privilege level.
// RULE9: Adjust after add: 3 clocks, updates auxiliary carry and carry.
// RULE10: Adjust before divide: 7 clocks, updates sign, zero and parity.
// RULE11: Adjust after multiply: 19 clocks, updates sign, zero and parity.
// RULE12: Adjust after subtract: 3 clocks, updates auxiliary carry and carry.
// RULE13: Add with carry register forms: nibble 1, all arithmetic flags, 1 clock.
// RULE14: Add with carry immediate: group 8, reg field 010, 1 clock.
// RULE15: Integer add register forms: nibble 0, arithmetic flags, 1 clock.
// RULE16: Register/memory count pairs use first for register, second for memory.
`timescale 1ns/1ps
`default_nettype none
module xad_decoder #(
  parameter logic [7:0] MISS_PENALTY = 8'h04
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic sys_rst,
  // AHB-Lite slave.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp
);

  // Total clock count for an instruction, including mode, miss and variable terms.
  function automatic logic [15:0] clk_total(input xad_pkg::xad_dec_s d,
                                            input logic [31:0] ctl,
                                            input logic [31:0] tim);
    logic [7:0] base;
    logic [7:0] alt;
    logic [15:0] tot;
    base = ctl[xad_pkg::CTL_PROT] ? (d.is_mem ? d.cnt_pm_mem : d.cnt_pm_reg)
                                  : (d.is_mem ? d.cnt_rl_mem : d.cnt_rl_reg); // RULE2 RULE16
    alt = tim[xad_pkg::TIM_ALT_LSB +: 8];
    tot = {8'h00, base};
    case (tim[2:0])
      xad_pkg::TK_REPEAT: tot = tot + ctl[xad_pkg::CTL_REP_LSB +: 8] * alt; // RULE7
      xad_pkg::TK_LEVEL: tot = tot + ctl[xad_pkg::CTL_LVL_LSB +: 8] * alt; // RULE7
      xad_pkg::TK_JUMP: tot = ctl[xad_pkg::CTL_TAKEN] ? tot : {8'h00, alt}; // RULE7
      xad_pkg::TK_PRIV: begin
        tot = (ctl[xad_pkg::CTL_CPL_LSB +: 2] <= ctl[xad_pkg::CTL_IO_PRIVILEGE_LEVEL_LSB +: 2])
              ? tot : {8'h00, alt}; // RULE8
      end
      default: tot = tot;
    endcase
    if (ctl[xad_pkg::CTL_MISS]) begin
      tot = tot + {8'h00, MISS_PENALTY}; // RULE2
    end
    clk_total = (tot == 16'h0000) ? 16'h0001 : tot;
  endfunction : clk_total

  typedef enum logic [1:0] {ST_IDLE, ST_RUN} xad_state_e;

  // Bus bookkeeping.
  logic wr_pend_r;
  logic wr_pend_nxt;
  logic [7:0] wr_addr_r;
  logic [7:0] wr_addr_nxt;
  logic [31:0] hrdata_r;
  logic [31:0] hrdata_nxt;
  logic acc;
  // Software-visible storage.
  logic [31:0] ctrl_r;
  logic [31:0] ctrl_nxt;
  logic [31:0] insn_r;
  logic [31:0] insn_nxt;
  logic [31:0] imm_r;
  logic [31:0] imm_nxt;
  logic [31:0] opa_r;
  logic [31:0] opa_nxt;
  logic [31:0] opb_r;
  logic [31:0] opb_nxt;
  logic [31:0] tim_r;
  logic [31:0] tim_nxt;
  xad_pkg::xad_flags_s flags_r;
  xad_pkg::xad_flags_s flags_nxt;
  logic [31:0] result_r;
  logic [31:0] result_nxt;
  // Execution state.
  xad_state_e state_r;
  xad_state_e state_nxt;
  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;
  logic [15:0] cycles_r;
  logic [15:0] cycles_nxt;
  logic done_r;
  logic done_nxt;
  logic illegal_r;
  logic illegal_nxt;
  logic [8:0] undef_r;
  logic [8:0] undef_nxt;
  xad_pkg::xad_dec_s dec_r;
  xad_pkg::xad_dec_s dec_nxt;
  logic [31:0] pend_res_r;
  logic [31:0] pend_res_nxt;
  xad_pkg::xad_flags_s pend_flg_r;
  xad_pkg::xad_flags_s pend_flg_nxt;
  logic [8:0] pend_und_r;
  logic [8:0] pend_und_nxt;
  // Decode and ALU wires.
  xad_pkg::xad_dec_s dec;
  logic [7:0] op0;
  logic [7:0] modrm;
  logic [31:0] src_b;
  logic [31:0] alu_res;
  xad_pkg::xad_flags_s alu_flg;
  logic [8:0] alu_und;
  logic start;

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_r;
  assign op0 = insn_r[7:0];
  assign modrm = insn_r[15:8];
  assign acc = hsel && htrans[1] && hready;

  // Instruction decode from the loaded bytes.
  always_comb begin
    dec = '0;
    dec.cls = xad_pkg::CLS_NONE;
    dec.is_mem = (modrm[7:6] != xad_pkg::MOD_REG);
    dec.dir = op0[1]; // RULE1
    dec.wide = op0[0]; // RULE1
    dec.sext = op0[1]; // RULE1
    dec.cnt_rl_reg = xad_pkg::CLK_ALU;
    dec.cnt_rl_mem = xad_pkg::CLK_ALU;
    dec.cnt_pm_reg = xad_pkg::CLK_ALU;
    dec.cnt_pm_mem = xad_pkg::CLK_ALU;
    if (op0 == xad_pkg::OPC_ADJ_ADD || op0 == xad_pkg::OPC_ADJ_SUB) begin
      dec.cls = (op0 == xad_pkg::OPC_ADJ_ADD) ? xad_pkg::CLS_ADJ_ADD : xad_pkg::CLS_ADJ_SUB;
      dec.is_mem = 1'b0;
      dec.cnt_rl_reg = xad_pkg::CLK_ADJ_ADD; // RULE9 RULE12
      dec.cnt_pm_reg = xad_pkg::CLK_ADJ_SUB; // RULE9 RULE12
    end else if ((op0 == xad_pkg::OPC_ADJ_DIV || op0 == xad_pkg::OPC_ADJ_MUL)
                 && modrm == xad_pkg::OPC_BASE10) begin
      dec.cls = (op0 == xad_pkg::OPC_ADJ_DIV) ? xad_pkg::CLS_ADJ_DIV : xad_pkg::CLS_ADJ_MUL;
      dec.is_mem = 1'b0;
      dec.cnt_rl_reg = (op0 == xad_pkg::OPC_ADJ_DIV) ? xad_pkg::CLK_ADJ_DIV
                                                      : xad_pkg::CLK_ADJ_MUL; // RULE10 RULE11
      dec.cnt_pm_reg = dec.cnt_rl_reg; // RULE10 RULE11
    end else if ((op0[7:4] == xad_pkg::NIB_ADD || op0[7:4] == xad_pkg::NIB_ADC)
                 && op0[3:2] == 2'b00) begin
      // Register and memory forms, [00dw] followed by a ModR/M byte.
      dec.cls = (op0[7:4] == xad_pkg::NIB_ADC) ? xad_pkg::CLS_ADC : xad_pkg::CLS_ADD; // RULE13 RULE15
      dec.sext = 1'b0;
    end else if ((op0[7:4] == xad_pkg::NIB_ADD || op0[7:4] == xad_pkg::NIB_ADC)
                 && op0[3:1] == 3'b010) begin
      // Immediate to accumulator, [010w].
      dec.cls = (op0[7:4] == xad_pkg::NIB_ADC) ? xad_pkg::CLS_ADC : xad_pkg::CLS_ADD;
      dec.is_mem = 1'b0;
      dec.dir = 1'b0;
      dec.sext = 1'b0;
    end else if (op0[7:4] == xad_pkg::NIB_GRP_IMM && op0[3:2] == 2'b00
                 && (modrm[5:3] == xad_pkg::REG_ADC || modrm[5:3] == xad_pkg::REG_ADD)) begin
      dec.cls = (modrm[5:3] == xad_pkg::REG_ADC) ? xad_pkg::CLS_ADC : xad_pkg::CLS_ADD; // RULE14
      dec.dir = 1'b0;
    end
    dec.illegal = (dec.cls == xad_pkg::CLS_NONE);
    // Immediate length: byte, sign-extended byte, or operand-size word.
    if ((dec.cls == xad_pkg::CLS_ADD || dec.cls == xad_pkg::CLS_ADC) && op0[3:2] != 2'b00) begin
      dec.imm_bytes = 3'h1;
    end else if (op0[7:4] == xad_pkg::NIB_GRP_IMM && !dec.illegal) begin
      dec.imm_bytes = (!dec.wide || dec.sext) ? 3'h1
                    : (ctrl_nxt[xad_pkg::CTL_OP16] ? 3'h2 : 3'h4); // RULE5
    end
    if (op0[3:1] == 3'b010 && dec.wide) begin
      dec.imm_bytes = ctrl_nxt[xad_pkg::CTL_OP16] ? 3'h2 : 3'h4; // RULE5
    end
    // Displacement length from mod and r/m, by address size.
    if (dec.is_mem && !dec.illegal) begin
      if (modrm[7:6] == 2'h1) begin
        dec.disp_bytes = 3'h1; // RULE6
      end else if (modrm[7:6] == 2'h2) begin
        dec.disp_bytes = ctrl_nxt[xad_pkg::CTL_AD16] ? 3'h2 : 3'h4; // RULE6
      end else if (ctrl_nxt[xad_pkg::CTL_AD16] ? modrm[2:0] == 3'h6 : modrm[2:0] == 3'h5) begin
        dec.disp_bytes = ctrl_nxt[xad_pkg::CTL_AD16] ? 3'h2 : 3'h4; // RULE6
      end
    end
  end

  // Source operand: sign-extended immediate byte, full immediate, or register value.
  always_comb begin
    if (dec.imm_bytes == 3'h1 && dec.sext) begin
      src_b = {{24{imm_r[7]}}, imm_r[7:0]}; // RULE5
    end else if (dec.imm_bytes != 3'h0) begin
      src_b = imm_r;
    end else begin
      src_b = opb_r;
    end
  end

  xad_alu u_alu (
    .cls(dec.cls),
    .wide(dec.wide),
    .op16(ctrl_nxt[xad_pkg::CTL_OP16]),
    .opa(opa_r),
    .opb(src_b),
    .flags_in(flags_r),
    .result(alu_res),
    .flags_out(alu_flg),
    .undef_mask(alu_und)
  );

  // Register file next state; the committing instruction wins over a software write.
  always_comb begin
    wr_pend_nxt = acc && hwrite;
    wr_addr_nxt = haddr[7:0];
    ctrl_nxt = ctrl_r;
    insn_nxt = insn_r;
    imm_nxt = imm_r;
    opa_nxt = opa_r;
    opb_nxt = opb_r;
    tim_nxt = tim_r;
    flags_nxt = flags_r;
    result_nxt = result_r;
    start = 1'b0;
    if (wr_pend_r) begin
      case (wr_addr_r)
        xad_pkg::A_CTRL: begin
          ctrl_nxt = hwdata & ~32'h0000_0001;
          start = hwdata[xad_pkg::CTL_START];
        end
        xad_pkg::A_INSN: insn_nxt = hwdata;
        xad_pkg::A_IMM: imm_nxt = hwdata;
        xad_pkg::A_OPA: opa_nxt = hwdata;
        xad_pkg::A_OPB: opb_nxt = hwdata;
        xad_pkg::A_FLAGS: flags_nxt = hwdata[8:0]; // RULE3
        xad_pkg::A_TIMING: tim_nxt = hwdata;
        default: ctrl_nxt = ctrl_nxt;
      endcase
    end
    if (state_r == ST_RUN && cnt_r == 16'h0001) begin
      flags_nxt = pend_flg_r; // RULE3
      result_nxt = pend_res_r;
    end
    hrdata_nxt = hrdata_r;
    if (acc && !hwrite) begin
      case (haddr[7:0])
        xad_pkg::A_CTRL: hrdata_nxt = ctrl_r;
        xad_pkg::A_STATUS: begin
          hrdata_nxt = {7'h00, undef_r, 13'h0000, illegal_r, done_r, state_r == ST_RUN};
        end
        xad_pkg::A_INSN: hrdata_nxt = insn_r;
        xad_pkg::A_IMM: hrdata_nxt = imm_r;
        xad_pkg::A_OPA: hrdata_nxt = opa_r;
        xad_pkg::A_OPB: hrdata_nxt = opb_r;
        xad_pkg::A_FLAGS: hrdata_nxt = {23'h000000, flags_r};
        xad_pkg::A_TIMING: hrdata_nxt = tim_r;
        xad_pkg::A_RESULT: hrdata_nxt = result_r;
        xad_pkg::A_DECODE: hrdata_nxt = {dec_r.illegal, dec_r.cls, dec_r.is_mem, dec_r.dir,
                                         dec_r.wide, dec_r.sext, 2'h0, dec_r.imm_bytes,
                                         dec_r.disp_bytes, dec_r.cnt_rl_reg,
                                         dec_r.cnt_rl_mem};
        xad_pkg::A_CYCLES: hrdata_nxt = {16'h0000, cycles_r};
        default: hrdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  // Execution sequencer: a start while running is ignored.
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    cycles_nxt = cycles_r;
    done_nxt = done_r;
    illegal_nxt = illegal_r;
    undef_nxt = undef_r;
    dec_nxt = dec_r;
    pend_res_nxt = pend_res_r;
    pend_flg_nxt = pend_flg_r;
    pend_und_nxt = pend_und_r;
    case (state_r)
      ST_IDLE: begin
        if (start) begin
          dec_nxt = dec;
          done_nxt = dec.illegal;
          illegal_nxt = dec.illegal;
          if (!dec.illegal) begin
            cnt_nxt = clk_total(dec, ctrl_nxt, tim_r);
            cycles_nxt = cnt_nxt;
            pend_res_nxt = alu_res;
            pend_flg_nxt = alu_flg;
            pend_und_nxt = alu_und;
            state_nxt = ST_RUN;
          end
        end
      end
      ST_RUN: begin
        cnt_nxt = cnt_r - 16'h0001;
        if (cnt_r == 16'h0001) begin
          done_nxt = 1'b1;
          undef_nxt = pend_und_r;
          state_nxt = ST_IDLE;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  // State registers.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      hrdata_r <= xad_pkg::WORD_RST;
      ctrl_r <= xad_pkg::CTRL_RST;
      insn_r <= xad_pkg::WORD_RST;
      imm_r <= xad_pkg::WORD_RST;
      opa_r <= xad_pkg::WORD_RST;
      opb_r <= xad_pkg::WORD_RST;
      tim_r <= xad_pkg::WORD_RST;
      flags_r <= xad_pkg::FLAGS_RST;
      result_r <= xad_pkg::WORD_RST;
      state_r <= ST_IDLE;
      cnt_r <= 16'h0000;
      cycles_r <= 16'h0000;
      done_r <= 1'b0;
      illegal_r <= 1'b0;
      undef_r <= 9'h000;
      dec_r <= '0;
      pend_res_r <= xad_pkg::WORD_RST;
      pend_flg_r <= xad_pkg::FLAGS_RST;
      pend_und_r <= 9'h000;
    end else begin
      wr_pend_r <= wr_pend_nxt;
      wr_addr_r <= wr_addr_nxt;
      hrdata_r <= hrdata_nxt;
      ctrl_r <= ctrl_nxt;
      insn_r <= insn_nxt;
      imm_r <= imm_nxt;
      opa_r <= opa_nxt;
      opb_r <= opb_nxt;
      tim_r <= tim_nxt;
      flags_r <= flags_nxt;
      result_r <= result_nxt;
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      cycles_r <= cycles_nxt;
      done_r <= done_nxt;
      illegal_r <= illegal_nxt;
      undef_r <= undef_nxt;
      dec_r <= dec_nxt;
      pend_res_r <= pend_res_nxt;
      pend_flg_r <= pend_flg_nxt;
      pend_und_r <= pend_und_nxt;
    end
  end

endmodule : xad_decoder
`default_nettype wire

// ---- hdl/xad_pkg.sv ----
// Purpose: Shared constants and types for the decimal-adjust and add decode block.
// Assumes: 32-bit AHB-Lite register access, one word per register.
// Notes: Flag word layout is carry in bit 0 up to overflow in bit 8.
package xad_pkg;

  // Register byte offsets.
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_STATUS = 8'h04;
  localparam logic [7:0] A_INSN = 8'h08;
  localparam logic [7:0] A_IMM = 8'h0C;
  localparam logic [7:0] A_OPA = 8'h10;
  localparam logic [7:0] A_OPB = 8'h14;
  localparam logic [7:0] A_FLAGS = 8'h18;
  localparam logic [7:0] A_TIMING = 8'h1C;
  localparam logic [7:0] A_RESULT = 8'h20;
  localparam logic [7:0] A_DECODE = 8'h24;
  localparam logic [7:0] A_CYCLES = 8'h28;

  // Control word and timing word field positions.
  localparam int CTL_START = 0;
  localparam int CTL_PROT = 1;
  localparam int CTL_MISS = 2;
  localparam int CTL_OP16 = 3;
  localparam int CTL_AD16 = 4;
  localparam int CTL_TAKEN = 5;
  localparam int CTL_CPL_LSB = 8;
  localparam int CTL_IO_PRIVILEGE_LEVEL_LSB = 12;
  localparam int CTL_REP_LSB = 16;
  localparam int CTL_LVL_LSB = 24;
  localparam int TIM_ALT_LSB = 8;

  // Values after reset.
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] WORD_RST = 32'h0000_0000;
  localparam logic [8:0] FLAGS_RST = 9'h000;

  // Opcode bytes and groups.
  localparam logic [7:0] OPC_ADJ_ADD = 8'h37;
  localparam logic [7:0] OPC_ADJ_SUB = 8'h3F;
  localparam logic [7:0] OPC_ADJ_DIV = 8'hD5;
  localparam logic [7:0] OPC_ADJ_MUL = 8'hD4;
  localparam logic [7:0] OPC_BASE10 = 8'h0A;
  localparam logic [3:0] NIB_ADD = 4'h0;
  localparam logic [3:0] NIB_ADC = 4'h1;
  localparam logic [3:0] NIB_GRP_IMM = 4'h8;
  localparam logic [2:0] REG_ADD = 3'h0;
  localparam logic [2:0] REG_ADC = 3'h2;
  localparam logic [1:0] MOD_REG = 2'h3;

  // Clock counts on a hit, identical in real and protected mode.
  localparam logic [7:0] CLK_ADJ_ADD = 8'h03;
  localparam logic [7:0] CLK_ADJ_SUB = 8'h03;
  localparam logic [7:0] CLK_ADJ_DIV = 8'h07;
  localparam logic [7:0] CLK_ADJ_MUL = 8'h13;
  localparam logic [7:0] CLK_ALU = 8'h01;

  // Variable timing kinds held in the timing register.
  localparam logic [2:0] TK_FIXED = 3'h0;
  localparam logic [2:0] TK_REPEAT = 3'h1;
  localparam logic [2:0] TK_LEVEL = 3'h2;
  localparam logic [2:0] TK_JUMP = 3'h3;
  localparam logic [2:0] TK_PRIV = 3'h4;

  typedef enum logic [2:0] {
    CLS_NONE, CLS_ADJ_ADD, CLS_ADJ_SUB, CLS_ADJ_DIV, CLS_ADJ_MUL, CLS_ADD, CLS_ADC
  } xad_cls_e;

  typedef enum logic [2:0] {EFF_KEEP, EFF_MOD, EFF_CLR, EFF_SET, EFF_UNDEF} xad_eff_e;

  typedef struct packed {
    logic overflow_flag;
    logic direction_flag;
    logic interrupt_flag;
    logic trap_flag;
    logic sign_flag;
    logic zero_flag;
    logic auxiliary_carry_flag;
    logic parity_flag;
    logic carry_flag;
  } xad_flags_s;

  typedef struct packed {
    logic illegal;
    xad_cls_e cls;
    logic is_mem;
    logic dir;
    logic wide;
    logic sext;
    logic [2:0] imm_bytes;
    logic [2:0] disp_bytes;
    logic [7:0] cnt_rl_reg;
    logic [7:0] cnt_rl_mem;
    logic [7:0] cnt_pm_reg;
    logic [7:0] cnt_pm_mem;
  } xad_dec_s;

endpackage : xad_pkg

// ---- hdl/xad_alu.sv ----
// Purpose: Result and flag computation for the adjust and add instructions.
// Assumes: Operands already selected by the decoder; purely combinational.
// Notes: Undefined flags keep their old value and are reported in a mask.
`timescale 1ns/1ps
`default_nettype none
module xad_alu (
  // Operation.
  input wire xad_pkg::xad_cls_e cls,
  input wire logic wide,
  input wire logic op16,
  // Operands and flags in.
  input wire logic [31:0] opa,
  input wire logic [31:0] opb,
  input wire xad_pkg::xad_flags_s flags_in,
  // Results.
  output logic [31:0] result,
  output xad_pkg::xad_flags_s flags_out,
  output logic [8:0] undef_mask
);

  // Applies one flag effect; undefined keeps the old value so software sees no glitch.
  function automatic logic eff_apply(input xad_pkg::xad_eff_e e, input logic old, input logic v);
    case (e)
      xad_pkg::EFF_MOD: eff_apply = v;
      xad_pkg::EFF_CLR: eff_apply = 1'b0;
      xad_pkg::EFF_SET: eff_apply = 1'b1;
      default: eff_apply = old;
    endcase
  endfunction : eff_apply

  logic [32:0] sum;
  logic [31:0] mask;
  logic [7:0] al;
  logic [7:0] ah;
  logic [15:0] prod;
  xad_pkg::xad_flags_s calc;
  xad_pkg::xad_eff_e eff [9];

  // Arithmetic, per-flag effects and final flag word.
  always_comb begin
    mask = wide ? (op16 ? 32'h0000_FFFF : 32'hFFFF_FFFF) : 32'h0000_00FF;
    sum = {1'b0, opa & mask} + {1'b0, opb & mask}
      + {32'h0000_0000, (cls == xad_pkg::CLS_ADC) & flags_in.carry_flag};
    al = opa[7:0];
    ah = opa[15:8];
    prod = 16'h0000;
    calc = flags_in;
    result = opa;
    for (int i = 0; i < 9; i++) begin
      eff[i] = xad_pkg::EFF_KEEP;
    end
    case (cls)
      xad_pkg::CLS_ADJ_ADD, xad_pkg::CLS_ADJ_SUB: begin
        if ((al[3:0] > 4'h9) || flags_in.auxiliary_carry_flag) begin
          al = (cls == xad_pkg::CLS_ADJ_ADD) ? al + 8'h06 : al - 8'h06;
          ah = (cls == xad_pkg::CLS_ADJ_ADD) ? ah + 8'h01 : ah - 8'h01;
          calc.auxiliary_carry_flag = 1'b1;
          calc.carry_flag = 1'b1;
        end else begin
          calc.auxiliary_carry_flag = 1'b0;
          calc.carry_flag = 1'b0;
        end
        result = {opa[31:16], ah, 4'h0, al[3:0]};
        eff = '{xad_pkg::EFF_UNDEF, xad_pkg::EFF_KEEP, xad_pkg::EFF_KEEP, xad_pkg::EFF_KEEP,
                xad_pkg::EFF_UNDEF, xad_pkg::EFF_UNDEF, xad_pkg::EFF_MOD, xad_pkg::EFF_UNDEF,
                xad_pkg::EFF_MOD}; // RULE9 RULE12
      end
      xad_pkg::CLS_ADJ_DIV, xad_pkg::CLS_ADJ_MUL: begin
        if (cls == xad_pkg::CLS_ADJ_DIV) begin
          prod = {8'h00, al} + ({8'h00, ah} * {8'h00, xad_pkg::OPC_BASE10});
          al = prod[7:0];
          ah = 8'h00;
        end else begin
          ah = al / xad_pkg::OPC_BASE10;
          al = al % xad_pkg::OPC_BASE10;
        end
        result = {opa[31:16], ah, al};
        calc.sign_flag = al[7];
        calc.zero_flag = (al == 8'h00);
        calc.parity_flag = ~^al;
        eff = '{xad_pkg::EFF_UNDEF, xad_pkg::EFF_KEEP, xad_pkg::EFF_KEEP, xad_pkg::EFF_KEEP,
                xad_pkg::EFF_MOD, xad_pkg::EFF_MOD, xad_pkg::EFF_UNDEF, xad_pkg::EFF_MOD,
                xad_pkg::EFF_UNDEF}; // RULE10 RULE11
      end
      xad_pkg::CLS_ADD, xad_pkg::CLS_ADC: begin
        result = (opa & ~mask) | (sum[31:0] & mask);
        calc.carry_flag = wide ? (op16 ? sum[16] : sum[32]) : sum[8];
        calc.sign_flag = wide ? (op16 ? sum[15] : sum[31]) : sum[7];
        calc.overflow_flag = wide ? (op16 ? (opa[15] == opb[15]) && (sum[15] != opa[15])
                                          : (opa[31] == opb[31]) && (sum[31] != opa[31]))
                                  : (opa[7] == opb[7]) && (sum[7] != opa[7]);
        calc.zero_flag = ((sum[31:0] & mask) == 32'h0000_0000);
        calc.auxiliary_carry_flag = opa[4] ^ opb[4] ^ sum[4];
        calc.parity_flag = ~^sum[7:0];
        eff = '{xad_pkg::EFF_MOD, xad_pkg::EFF_KEEP, xad_pkg::EFF_KEEP, xad_pkg::EFF_KEEP,
                xad_pkg::EFF_MOD, xad_pkg::EFF_MOD, xad_pkg::EFF_MOD, xad_pkg::EFF_MOD,
                xad_pkg::EFF_MOD}; // RULE13 RULE15
      end
      default: begin
        result = opa;
      end
    endcase
    // Effects are indexed from overflow (0) down to carry (8), matching the struct order.
    for (int i = 0; i < 9; i++) begin
      flags_out[8 - i] = eff_apply(eff[i], flags_in[8 - i], calc[8 - i]); // RULE4
      undef_mask[8 - i] = (eff[i] == xad_pkg::EFF_UNDEF);
    end
  end

endmodule : xad_alu
`default_nettype wire

// ---- bench/xad_decoder_checker.sv ----
// Purpose: Decode-field checks for the adjust and add decoder, seen at its bus ports.
// Assumes: The instruction word changes only through bus writes.
// Notes: Each decode read is judged against a shadow of the instruction word.
`timescale 1ns/1ps
`default_nettype none
module xad_decoder_checker (
  // Clock and reset.
  input wire logic clk,
  input wire logic sys_rst,
  // Bus.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  input wire logic [31:0] hrdata
);
  logic take;
  logic wr_q;
  logic rd_q;
  logic [15:0] ins;
  // An address phase is taken on select, a non-idle transfer and ready.
  assign take = hsel && htrans[1] && hready;
  // The shadow follows the write data phase, so a stale shadow cannot hide a fault.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      ins <= 16'h0000;
    end else begin
      wr_q <= take && hwrite && haddr[7:0] == xad_pkg::A_INSN;
      rd_q <= take && !hwrite && haddr[7:0] == xad_pkg::A_DECODE;
      if (wr_q) ins <= hwdata[15:0];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_adj_add_dec: assert property (rd_q && ins[7:0] == 8'h37 |->
    hrdata[30:28] == 3'h1 && hrdata[15:8] == 8'h03) else $error("adjust add decode");
  a_adj_sub_dec: assert property (rd_q && ins[7:0] == 8'h3F |->
    hrdata[30:28] == 3'h2 && hrdata[15:8] == 8'h03) else $error("adjust sub decode");
  a_adj_div_dec: assert property (rd_q && ins == 16'h0AD5 |->
    hrdata[30:28] == 3'h3 && hrdata[15:8] == 8'h07) else $error("adjust div decode");
  a_adj_mul_dec: assert property (rd_q && ins == 16'h0AD4 |->
    hrdata[30:28] == 3'h4 && hrdata[15:8] == 8'h13) else $error("adjust mul decode");
  a_adc_reg_dec: assert property (rd_q && ins[7:2] == 6'h04 && ins[15:14] == 2'h3 |->
    hrdata[30:27] == 4'hC && hrdata[15:8] == 8'h01) else $error("adc reg decode");
  a_add_reg_dec: assert property (rd_q && ins[7:2] == 6'h00 && ins[15:14] == 2'h3 |->
    hrdata[30:28] == 3'h5 && hrdata[26:25] == ins[1:0]) else $error("add reg decode");
  a_adc_imm_dec: assert property (rd_q && ins[7:2] == 6'h20 && ins[13:11] == 3'h2 |->
    hrdata[30:28] == 3'h6 && hrdata[24] == ins[1]) else $error("adc imm decode");
  a_imm_sext: assert property (rd_q && ins[7:0] == 8'h83 |->
    hrdata[21:19] == 3'h1) else $error("sign-extended immediate size");
endmodule : xad_decoder_checker
`default_nettype wire

// ---- bench/tb_xad_decoder.sv ----
// Purpose: Self-checking bench for the adjust and add decoder.
// Assumes: One zero-wait slave; the bus master keeps transfers unpipelined.
// Notes: Busy is probed in the last counted cycle, done just after it.
`timescale 1ns/1ps
`default_nettype none
module tb_xad_decoder;
  localparam logic [7:0] MISS = 8'h04;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic hsel = 1'b1;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hready;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  int n_errors = 0;
  int samples_checked = 0;
  // Free-running clock; the single slave drives the bus ready.
  always #5 clk = ~clk;
  assign hready = hreadyout;
  xad_decoder #(.MISS_PENALTY(MISS)) DUT (.clk(clk), .sys_rst(sys_rst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));
  task automatic summarize();
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : summarize
  task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : check
  // Waits for ready with a bound, so a stuck slave ends the run.
  task automatic step();
    int i;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (hreadyout !== 1'b1 && i < 64);
    if (hreadyout !== 1'b1) begin
      n_errors++;
      summarize();
    end
  endtask : step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= 1'b1;
    step();
    htrans <= 2'h0;
    hwdata <= d;
    step();
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= 1'b0;
    step();
    htrans <= 2'h0;
    step();
    d = hrdata;
    check("resp", {31'h0, hresp}, 32'h0);
  endtask : rd
  // Loads one instruction, starts it, and judges timing, result, flags and mask.
  task automatic run(input logic [31:0] ctl, input logic [31:0] tim, input logic [15:0] ins,
    input logic [31:0] a, input logic [31:0] b, input logic [31:0] im, input logic [8:0] f,
    input int t, input logic [31:0] res, input logic [8:0] ef, input logic [8:0] mask);
    logic [31:0] d;
    wr(xad_pkg::A_INSN, {16'h0, ins});
    wr(xad_pkg::A_OPA, a);
    wr(xad_pkg::A_OPB, b);
    wr(xad_pkg::A_IMM, im);
    wr(xad_pkg::A_FLAGS, {23'h0, f});
    wr(xad_pkg::A_TIMING, tim);
    wr(xad_pkg::A_CTRL, ctl | 32'h1);
    repeat (t - 1) @(posedge clk);
    rd(xad_pkg::A_STATUS, d);
    check("busy", {30'h0, d[1:0]}, 32'h1);
    rd(xad_pkg::A_STATUS, d);
    check("done", {29'h0, d[2:0]}, 32'h2);
    check("mask", {23'h0, d[24:16]}, {23'h0, mask});
    rd(xad_pkg::A_RESULT, d);
    check("result", d, res);
    rd(xad_pkg::A_FLAGS, d);
    check("flags", {23'h0, d[8:0]}, {23'h0, ef});
    rd(xad_pkg::A_CYCLES, d);
    check("cycles", d, t);
    rd(xad_pkg::A_DECODE, d);
  endtask : run
  task automatic t_reset();
    logic [31:0] d;
    rd(xad_pkg::A_STATUS, d);
    check("status", d, xad_pkg::WORD_RST);
    rd(xad_pkg::A_FLAGS, d);
    check("flags0", d, xad_pkg::WORD_RST);
    rd(8'h3C, d);
    check("unmapped", d, 32'h0);
  endtask : t_reset
  task automatic t_adjust();
    run(0, 0, 16'h0037, 32'h000B, 0, 0, 9'h0E0, 3, 32'h0101, 9'h0E5, 9'h11A);
    run(0, 0, 16'h003F, 32'h020B, 0, 0, 9'h0E0, 3, 32'h0105, 9'h0E5, 9'h11A);
    run(0, 0, 16'h0AD5, 32'h0207, 0, 0, 9'h0E0, 7, 32'h001B, 9'h0E2, 9'h105);
    run(0, 0, 16'h0AD4, 32'h003F, 0, 0, 9'h0E0, 19, 32'h0603, 9'h0E2, 9'h105);
  endtask : t_adjust
  task automatic t_alu();
    run(0, 0, 16'hC011, 32'h7FFFFFFF, 0, 0, 9'h0E1, 1, 32'h80000000, 9'h1F6, 0);
    run(32'h8, 0, 16'hC001, 32'h1234FFFF, 1, 0, 9'h0E1, 1, 32'h12340000, 9'h0EF, 0);
    run(0, 0, 16'hD083, 1, 0, 32'hFF, 9'h000, 1, 0, 9'h00F, 0);
  endtask : t_alu
  task automatic t_timing();
    run(0, 32'h0403, 16'hC011, 1, 2, 0, 0, 4, 3, 9'h002, 0);
    run(32'h00030000, 32'h0201, 16'hC011, 1, 2, 0, 0, 7, 3, 9'h002, 0);
    run(32'h0300, 32'h0504, 16'hC011, 1, 2, 0, 0, 5, 3, 9'h002, 0);
    run(32'h4, 0, 16'hC011, 1, 2, 0, 0, 1 + int'(MISS), 3, 9'h002, 0);
  endtask : t_timing
  task automatic t_illegal();
    logic [31:0] d;
    wr(xad_pkg::A_INSN, 32'h0BD5);
    wr(xad_pkg::A_FLAGS, 32'h155);
    wr(xad_pkg::A_CTRL, 32'h1);
    repeat (2) @(posedge clk);
    rd(xad_pkg::A_STATUS, d);
    check("illegal", {29'h0, d[2:0]}, 32'h6);
    rd(xad_pkg::A_FLAGS, d);
    check("kept", d, 32'h155);
  endtask : t_illegal
  // Main sequence: reset, then each scenario in turn.
  initial begin
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_adjust();
    t_alu();
    t_timing();
    t_illegal();
    summarize();
  end
endmodule : tb_xad_decoder
bind xad_decoder xad_decoder_checker u_chk (.clk(clk), .sys_rst(sys_rst), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hwdata(hwdata),
  .hrdata(hrdata));
`default_nettype wire
